// [spi_master_pkg.sv]
// Package of register map, field layout and types for the master SPI mode block
package spi_master_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] data_buffer_reg_addr        = 8'h00;
  localparam logic [7:0] spi_status_a_addr           = 8'h04;
  localparam logic [7:0] spi_ctrl_b_enables_addr     = 8'h08;
  localparam logic [7:0] spi_ctrl_c_mode_format_addr = 8'h0C;
  localparam logic [7:0] bit_rate_divisor_addr       = 8'h10;
  localparam logic [7:0] irq_global_addr             = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int rx_done_pos      = 7;
  localparam int tx_done_pos      = 6;
  localparam int tx_empty_pos     = 5;
  localparam int receiver_on_pos  = 4;
  localparam int transmitter_pos  = 3;
  localparam int lsb_first_pos    = 2;
  localparam int phase_pos        = 1;
  localparam int polarity_pos     = 0;

  // ==========================================================================
  // Reset values and codes
  // ==========================================================================
  localparam logic [7:0] ctrl_b_reset   = 8'h06;
  localparam logic [7:0] ctrl_c_reset   = 8'h06;
  localparam logic [7:0] ctrl_b_wmask   = 8'hF8;
  localparam logic [7:0] ctrl_c_wmask   = 8'hC7;
  localparam logic [1:0] op_async       = 2'b00;
  localparam logic [1:0] op_sync        = 2'b01;
  localparam logic [1:0] master_spi_op  = 2'b11;
  localparam logic [1:0] resp_okay      = 2'b00;
  localparam logic [1:0] resp_slverr    = 2'b10;
  localparam logic [11:0] divisor_reset = 12'h000;
  localparam logic [3:0] bits_per_frame = 4'h8;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_lead  = 2'b01,
    st_trail = 2'b10
  } shift_state_t;

  // Serial link pins as one bundle
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
  } link_out_t;

endpackage

// [usart_master_spi.sv]
// Master-only SPI mode of a USART with an AXI4-Lite register slave
// Behaviour
// [R1] Receive-done irq needs enable, global, flag
// [R2] Transmit-done irq needs enable, global, flag
// [R3] Empty irq needs enable, global, empty flag
// [R4] Receiver enable claims serial input pin
// [R5] Receiver disable flushes receive buffer
// [R6] Only transmitter makes clock; receiver-only idle
// [R7] Transmitter enable drives serial output pin
// [R8] Transmitter disable waits for pending data
// [R9] Software writes zeros to reserved bits
// [R10] Two-bit field selects operating mode
// [R11] Format bits apply with mode write
// [R12] Order bit one shifts LSB first
// [R13] Phase bit picks leading or trailing sample
// [R14] Polarity bit sets idle clock level
// [R15] Double-buffered transmit, extra receive level
// [R16] No collision flag, no double speed
// [R17] Master only, no slave select
// [R18] Data write starts transfer when shifter free
// [R19] Transmit-done sets when idle, clears on one
// [R20] Eight bits, full duplex per transfer
`timescale 1ns/1ps
`default_nettype none

module usart_master_spi #(
  parameter int div_width = 12
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Serial link pins
  output logic                           serial_clock_pin_o,
  output logic                           serial_clock_pin_oe,
  output logic                           serial_out_pin_o,
  output logic                           serial_out_pin_oe,
  input  wire logic                      serial_in_pin,
  output logic                           serial_in_claimed,
  // Interrupt requests towards the core
  output logic                           rx_done_irq,
  output logic                           tx_done_irq,
  output logic                           tx_empty_irq,
  input  wire logic                      tx_done_irq_ack
);

  // ==========================================================================
  // State record
  // ==========================================================================
  typedef struct packed {
    logic                          awv;      // Write address held
    logic [7:0]                    awa;      // Held write address
    logic                          wv;       // Write data held
    logic [31:0]                   wd;       // Held write data
    logic [3:0]                    ws;       // Held strobes
    logic                          bv;       // Write response pending
    logic [1:0]                    br;       // Write response code
    logic                          rv;       // Read data pending
    logic [31:0]                   rd;       // Read data
    logic [1:0]                    rr;       // Read response code
    logic [7:0]                    ctrl_b;   // Enables register
    logic [7:0]                    ctrl_c;   // Mode and format register
    logic [div_width-1:0]          div;      // Bit rate divisor
    logic                          gie;      // Global interrupt enable
    logic [7:0]                    txbuf;    // Transmit buffer
    logic                          txfull;   // Transmit buffer holds data
    logic [7:0]                    shreg;    // Shift register
    logic [3:0]                    bitcnt;   // Bits left
    spi_master_pkg::shift_state_t  st;       // Shifter state
    logic [div_width-1:0]          cnt;      // Half period counter
    logic                          sck;      // Serial clock level
    logic                          mosi;     // Output data
    logic                          txon;     // Transmitter really on
    logic                          txdone;   // Transmit done flag
    logic [7:0]                    rxb0;     // Oldest received byte
    logic [7:0]                    rxb1;     // Second received byte
    logic [1:0]                    rxn;      // Received bytes held
    logic [1:0]                    insync;   // Input synchroniser
  } state_t;

  state_t s_q;
  state_t s_d;

  // Combinational helpers
  logic       spi_mode;
  logic       cpol;
  logic       cpha;
  logic       lsbf;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] status_a;
  logic       half_tick;
  logic       in_bit;

  // Return the bit that goes out next
  function automatic logic next_out(input logic [7:0] v, input logic lf);
    return lf ? v[0] : v[7];
  endfunction

  // Shift one bit in at the far end from the outgoing bit
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lf, input logic b);
    return lf ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    s_d      = s_q;
    spi_mode = (s_q.ctrl_c[7:6] == spi_master_pkg::master_spi_op);                 // [R10]
    cpol     = s_q.ctrl_c[spi_master_pkg::polarity_pos];                           // [R14]
    cpha     = s_q.ctrl_c[spi_master_pkg::phase_pos];                              // [R13]
    lsbf     = s_q.ctrl_c[spi_master_pkg::lsb_first_pos];                          // [R12]
    in_bit   = s_q.insync[1];
    half_tick = (s_q.cnt == s_q.div);
    wr_go    = s_q.awv && s_q.wv && !s_q.bv;
    rd_go    = s_axi_arvalid && !s_q.rv;
    // Flag layout; no collision or error bits exist [R16]
    status_a = {s_q.rxn != 2'b00, s_q.txdone, !s_q.txfull, 5'h00};

    // Input synchroniser for the serial input
    s_d.insync = {s_q.insync[0], serial_in_pin};

    // Write channels accepted in either order
    if (s_axi_awvalid && !s_q.awv) begin
      s_d.awv = 1'b1;
      s_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wv) begin
      s_d.wv = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
    end

    // Transmit-done cleared by interrupt acknowledge
    if (tx_done_irq_ack) begin
      s_d.txdone = 1'b0;                                                           // [R19]
    end

    // Register write
    if (wr_go) begin
      s_d.awv = 1'b0;
      s_d.wv  = 1'b0;
      s_d.bv  = 1'b1;
      s_d.br  = spi_master_pkg::resp_okay;
      unique case ({s_q.awa[7:2], 2'b00})
        spi_master_pkg::data_buffer_reg_addr: begin
          if (s_q.ws[0] && !s_q.txfull) begin
            s_d.txbuf  = s_q.wd[7:0];                                              // [R18]
            s_d.txfull = 1'b1;
          end
        end
        spi_master_pkg::spi_status_a_addr: begin
          if (s_q.ws[0] && s_q.wd[spi_master_pkg::tx_done_pos]) begin
            s_d.txdone = 1'b0;                                                     // [R19]
          end
        end
        spi_master_pkg::spi_ctrl_b_enables_addr: begin
          // Reserved low bits keep their fixed values [R9]
          if (s_q.ws[0]) begin
            s_d.ctrl_b = (s_q.wd[7:0] & spi_master_pkg::ctrl_b_wmask) |
                         (spi_master_pkg::ctrl_b_reset & ~spi_master_pkg::ctrl_b_wmask);
          end
        end
        spi_master_pkg::spi_ctrl_c_mode_format_addr: begin
          // Mode and format land in one update [R11]
          if (s_q.ws[0]) begin
            s_d.ctrl_c = s_q.wd[7:0] & spi_master_pkg::ctrl_c_wmask;               // [R11]
          end
        end
        spi_master_pkg::bit_rate_divisor_addr: begin
          if (s_q.ws[0]) begin
            s_d.div[7:0] = s_q.wd[7:0];
          end
          if (s_q.ws[1]) begin
            s_d.div[div_width-1:8] = s_q.wd[div_width-1:8];
          end
        end
        spi_master_pkg::irq_global_addr: begin
          if (s_q.ws[0]) begin
            s_d.gie = s_q.wd[0];
          end
        end
        default: begin
          s_d.br = spi_master_pkg::resp_slverr;
        end
      endcase
    end

    // Transmitter on follows enable, off only when drained [R8]
    if (s_q.ctrl_b[spi_master_pkg::transmitter_pos]) begin
      s_d.txon = 1'b1;
    end else if (!s_q.txfull && s_q.st == spi_master_pkg::st_idle) begin
      s_d.txon = 1'b0;                                                             // [R8]
    end

    // Shifter; clock made only here, so receiver alone does nothing [R6]
    unique case (s_q.st)
      spi_master_pkg::st_idle: begin
        s_d.sck = cpol;                                                            // [R14]
        s_d.cnt = '0;
        if (s_q.txon && spi_mode && s_q.txfull) begin
          s_d.shreg  = s_q.txbuf;                                                  // [R15]
          s_d.txfull = 1'b0;
          s_d.bitcnt = spi_master_pkg::bits_per_frame;                             // [R20]
          s_d.mosi   = next_out(s_q.txbuf, lsbf);
          s_d.st     = spi_master_pkg::st_lead;
        end
      end
      spi_master_pkg::st_lead: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (half_tick) begin
          s_d.cnt = '0;
          s_d.sck = !cpol;
          s_d.st  = spi_master_pkg::st_trail;
          if (!cpha) begin
            s_d.shreg = shift_in(s_q.shreg, lsbf, in_bit);                         // [R13]
          end else begin
            s_d.mosi = next_out(s_q.shreg, lsbf);
          end
        end
      end
      spi_master_pkg::st_trail: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (half_tick) begin
          s_d.cnt    = '0;
          s_d.sck    = cpol;
          s_d.bitcnt = s_q.bitcnt - 1'b1;
          if (cpha) begin
            s_d.shreg = shift_in(s_q.shreg, lsbf, in_bit);                         // [R13]
          end
          if (s_q.bitcnt == 4'h1) begin
            // Byte done: full duplex receive lands in buffer [R20]
            s_d.st = spi_master_pkg::st_idle;
            if (s_q.ctrl_b[spi_master_pkg::receiver_on_pos]) begin
              if (s_q.rxn == 2'b00) begin
                s_d.rxb0 = cpha ? shift_in(s_q.shreg, lsbf, in_bit) : s_q.shreg;   // [R15]
                s_d.rxn  = 2'b01;
              end else if (s_q.rxn == 2'b01) begin
                s_d.rxb1 = cpha ? shift_in(s_q.shreg, lsbf, in_bit) : s_q.shreg;   // [R15]
                s_d.rxn  = 2'b10;
              end
            end
            if (!s_d.txfull) begin
              s_d.txdone = 1'b1;                                                   // [R19]
            end
          end else begin
            s_d.st = spi_master_pkg::st_lead;
            if (!cpha) begin
              s_d.mosi = next_out(s_q.shreg, lsbf);                                  // [R12]
            end
          end
        end
      end
      default: begin
        s_d.st = spi_master_pkg::st_idle;
      end
    endcase

    // Register read; data read pops the receive buffer
    if (rd_go) begin
      s_d.rv = 1'b1;
      s_d.rr = spi_master_pkg::resp_okay;
      s_d.rd = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        spi_master_pkg::data_buffer_reg_addr: begin
          s_d.rd[7:0] = s_q.rxb0;
          if (s_q.rxn != 2'b00) begin
            s_d.rxb0 = s_d.rxb1;          // Keeps a byte landing in this cycle [R15]
            s_d.rxn  = s_d.rxn - 1'b1;
          end
        end
        spi_master_pkg::spi_status_a_addr: begin
          s_d.rd[7:0] = status_a;
        end
        spi_master_pkg::spi_ctrl_b_enables_addr: begin
          s_d.rd[7:0] = s_q.ctrl_b;
        end
        spi_master_pkg::spi_ctrl_c_mode_format_addr: begin
          s_d.rd[7:0] = s_q.ctrl_c;
        end
        spi_master_pkg::bit_rate_divisor_addr: begin
          s_d.rd[div_width-1:0] = s_q.div;
        end
        spi_master_pkg::irq_global_addr: begin
          s_d.rd[0] = s_q.gie;
        end
        default: begin
          s_d.rr = spi_master_pkg::resp_slverr;
        end
      endcase
    end

    // Receiver off flushes everything unread [R5]
    if (!s_q.ctrl_b[spi_master_pkg::receiver_on_pos]) begin
      s_d.rxn = 2'b00;                                                             // [R5]
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.ctrl_b <= spi_master_pkg::ctrl_b_reset;
      s_q.ctrl_c <= spi_master_pkg::ctrl_c_reset;
      s_q.div    <= div_width'(spi_master_pkg::divisor_reset);
      s_q.st     <= spi_master_pkg::st_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = !s_q.awv;
  assign s_axi_wready  = !s_q.wv;
  assign s_axi_bvalid  = s_q.bv;
  assign s_axi_bresp   = s_q.br;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_rvalid  = s_q.rv;
  assign s_axi_rdata   = s_q.rd;
  assign s_axi_rresp   = s_q.rr;

  // Master-only pins, no slave select exists [R17]
  assign serial_clock_pin_o  = s_q.sck;                                            // [R17]
  assign serial_clock_pin_oe = s_q.txon;                                           // [R6]
  assign serial_out_pin_o    = s_q.mosi;
  assign serial_out_pin_oe   = s_q.txon;                                           // [R7]
  assign serial_in_claimed   = s_q.ctrl_b[spi_master_pkg::receiver_on_pos];        // [R4]

  // Interrupt gating
  assign rx_done_irq  = s_q.ctrl_b[spi_master_pkg::rx_done_pos] && s_q.gie && (s_q.rxn != 2'b00); // [R1]
  assign tx_done_irq  = s_q.ctrl_b[spi_master_pkg::tx_done_pos] && s_q.gie && s_q.txdone;         // [R2]
  assign tx_empty_irq = s_q.ctrl_b[spi_master_pkg::tx_empty_pos] && s_q.gie && !s_q.txfull;       // [R3]

endmodule

`default_nettype wire

// [spi_master_sva.sv]
// Checker of bus answers, link pins and interrupt lines of the SPI block
`timescale 1ns/1ps
`default_nettype none
module spi_master_sva (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Link and interrupt lines
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_out_pin_oe,
  input wire logic       serial_in_claimed,
  input wire logic       rx_done_irq,
  input wire logic       tx_done_irq,
  input wire logic       tx_done_irq_ack
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic       aw_bad_q;  // Last taken write address is unmapped
  logic [2:0] aw_age_q;  // Cycles since a write address was taken
  logic       ar_bad;    // Read address offered is unmapped
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign ar_bad = {s_axi_araddr[7:2], 2'h0} > spi_master_pkg::irq_global_addr;
  // Remember write address kind and age
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_bad_q <= 1'b0;
      aw_age_q <= 3'h7;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_bad_q <= {s_axi_awaddr[7:2], 2'h0} > spi_master_pkg::irq_global_addr;
      aw_age_q <= 3'h0;
    end else if (aw_age_q != 3'h7) begin
      aw_age_q <= aw_age_q + 3'h1;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  oe_pair_a: assert property (serial_clock_pin_oe == serial_out_pin_oe)
    else $error("link enables differ");
  sck_quiet_a: assert property ($changed(serial_clock_pin_o) && !serial_clock_pin_oe |->
    $past(serial_clock_pin_oe) || aw_age_q < 3'h6) else $error("clock moved while idle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer dropped");
  r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == ($past(ar_bad) ? spi_master_pkg::resp_slverr : spi_master_pkg::resp_okay))
    else $error("read answer late or wrong");
  wr_resp_a: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (aw_bad_q ? spi_master_pkg::resp_slverr : spi_master_pkg::resp_okay))
    else $error("write answer code wrong");
  rx_claim_a: assert property (rx_done_irq |-> serial_in_claimed || $past(serial_in_claimed))
    else $error("receive irq without receiver");
  ack_clear_a: assert property (tx_done_irq_ack |=> !tx_done_irq)
    else $error("done irq kept after ack");
endmodule
`default_nettype wire

// [spi_slave_model.sv]
// Behavioural SPI slave on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  // Link pins
  input wire logic        sck,
  input wire logic        sck_oe,
  input wire logic        mosi,
  output logic            miso,
  // Format and control from the bench
  input wire logic        cpol,
  input wire logic        cpha,
  input wire logic        lsb,
  input wire logic        clr,
  input wire logic [7:0]  tx_base,
  // Results
  output logic [7:0]      rx_byte,
  output logic [7:0]      frames
);
  int cnt;  // Bits sampled in this frame
  // Bit i of a byte in the chosen order
  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb ? b[i] : b[7-i];
  endfunction
  // Clear restarts framing; else sample on one edge, present the next bit on the other
  always @(sck or posedge clr) begin
    if (clr) begin
      cnt = 0;
      frames = 8'h00;
      miso = pick(tx_base, 0);
    end else if (sck_oe === 1'b1) begin
      if (sck ^ cpol ^ cpha) begin
        rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
        cnt++;
        if (cnt == 8) begin
          cnt = 0;
          frames++;
        end
      end else begin
        miso = pick(tx_base + frames, cnt);
      end
    end
  end
endmodule
`default_nettype wire

// [tb_usart_master_spi.sv]
// Self-checking bench for the master SPI block
`timescale 1ns/1ps
`default_nettype none
module tb_usart_master_spi;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        aclk = 1'b0, aresetn = 1'b0, tx_done_irq_ack = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        serial_clock_pin_o, serial_clock_pin_oe, serial_out_pin_o, serial_out_pin_oe;
  logic        serial_in_pin, serial_in_claimed, rx_done_irq, tx_done_irq, tx_empty_irq;
  logic        cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, clr = 1'b0;  // Slave model controls
  logic [7:0]  sb = 8'h00, mb, rxb, frames, f0;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  int          q[$];  // Expected receive buffer
  usart_master_spi #(.div_width(12)) dut (.*);
  spi_slave_model peer (.sck(serial_clock_pin_o), .sck_oe(serial_clock_pin_oe), .mosi(serial_out_pin_o),
    .miso(serial_in_pin), .cpol(cpol), .cpha(cpha), .lsb(lsb), .clr(clr), .tx_base(sb),
    .rx_byte(rxb), .frames(frames));
  always #5 aclk = ~aclk;
  // Cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic finish_test();
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a);
    logic ar_t, r_t;
    r_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      rd_v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Poll a status bit until it is set
  task automatic until_set(input int n);
    rd(8'h04);
    while (rd_v[n] !== 1'b1) rd(8'h04);
  endtask
  task automatic pulse_clr();
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    @(posedge aclk);
  endtask
  // One full-duplex byte, compared on both sides
  task automatic xfer(input logic [7:0] m);
    wr(8'h04, 32'h0000_0040);
    wr(8'h00, {24'h00_0000, m});
    until_set(6);
    chk(serial_clock_pin_o, cpol);
    chk(rxb, m);
    rd(8'h00);
    chk(rd_v, {24'h00_0000, sb});
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(32'h0000_8907));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pulse_clr();
    rd(8'h08);
    chk(rd_v[7:0], spi_master_pkg::ctrl_b_reset);
    rd(8'h0C);
    chk(rd_v[7:0], 8'h06);
    rd(8'h04);
    chk(rd_v[7:5], 3'h1);
    rd(8'h18);
    chk(resp, spi_master_pkg::resp_slverr);
    wr(8'h1C, 32'h0000_0000);
    chk(resp, spi_master_pkg::resp_slverr);
    wr(8'h10, 32'h0000_0007);  // Half period of 80 ns
    wr(8'h08, 32'h0000_0018);
    chk(serial_in_claimed, 1'b1);
    chk(serial_out_pin_oe, 1'b1);
    // Every order, phase and polarity
    for (int m = 0; m < 8; m++) begin
      {lsb, cpha, cpol} <= m[2:0];
      sb <= 8'($urandom);
      wr(8'h0C, {24'h00_0000, 2'h3, 3'h0, m[2:0]});
      pulse_clr();
      xfer(8'($urandom));
    end
    // Back to back writes, third byte overflows the receive side
    pulse_clr();
    wr(8'h00, 32'h0000_00A5);
    wr(8'h00, 32'h0000_003C);
    rd(8'h04);
    chk(rd_v[5], 1'b0);
    until_set(5);
    wr(8'h00, 32'h0000_000F);
    wr(8'h04, 32'h0000_0040);
    until_set(6);
    chk(frames, 8'h03);
    chk(rxb, 8'h0F);
    for (int i = 0; i < 3; i++) if (q.size() < 2) q.push_back((sb + i) % 256);
    for (int i = 0; i < 2; i++) begin
      rd(8'h00);
      chk(rd_v, q.pop_front());
    end
    rd(8'h04);
    chk(rd_v[7], 1'b0);
    // Transmitter off in mid-frame, then receiver off
    wr(8'h04, 32'h0000_0040);
    mb = 8'($urandom);
    wr(8'h00, {24'h00_0000, mb});
    wr(8'h08, 32'h0000_0010);
    chk(serial_out_pin_oe, 1'b1);
    until_set(6);
    repeat (4) @(posedge aclk);
    chk(serial_out_pin_oe, 1'b0);
    chk(rxb, mb);
    rd(8'h04);
    chk(rd_v[7], 1'b1);
    wr(8'h08, 32'h0000_0000);
    rd(8'h04);
    chk(rd_v[7], 1'b0);
    chk(serial_in_claimed, 1'b0);
    // Interrupt lines
    wr(8'h14, 32'h0000_0001);
    wr(8'h08, 32'h0000_0028);
    chk(tx_empty_irq, 1'b1);
    chk(tx_done_irq, 1'b0);
    wr(8'h14, 32'h0000_0000);
    chk(tx_empty_irq, 1'b0);
    wr(8'h14, 32'h0000_0001);
    wr(8'h08, 32'h0000_0048);
    chk(tx_done_irq, 1'b1);
    chk(tx_empty_irq, 1'b0);
    tx_done_irq_ack <= 1'b1;
    @(posedge aclk);
    tx_done_irq_ack <= 1'b0;
    @(posedge aclk);
    chk(tx_done_irq, 1'b0);
    wr(8'h08, 32'h0000_0098);
    pulse_clr();
    wr(8'h00, 32'h0000_005A);
    until_set(7);
    chk(rx_done_irq, 1'b1);
    wr(8'h14, 32'h0000_0000);
    chk(rx_done_irq, 1'b0);
    until_set(6);
    // Other mode codes start no transfer
    f0 = frames;
    for (int c = 0; c < 3; c++) begin
      wr(8'h0C, {24'h00_0000, c[1:0], 6'h00});
      wr(8'h00, 32'h0000_0033);
      repeat (140) @(posedge aclk);
    end
    chk(frames, f0);
    finish_test();
  end
endmodule
bind usart_master_spi spi_master_sva sva (.*);
`default_nettype wire
